//--- lses_pkg.sv
`default_nettype none
package lses_pkg;
  // register indexes as printed; byte address is four times the index
  localparam logic [7:0] IDX_PG_MASK_LO = 8'h19;
  localparam logic [7:0] IDX_ENABLE_SELECT = 8'h1a;
  localparam logic [7:0] IDX_EDGE_DELAY = 8'h1b;
  localparam logic [7:0] IDX_STATUS = 8'h1c;
  localparam int ADDR_W = 10;
  localparam logic [7:0] RESET_PG_MASK_LO = 8'h00;
  localparam logic [7:0] RESET_ENABLE_SELECT = 8'h00;
  localparam logic [7:0] RESET_EDGE_DELAY = 8'h00;
  // field positions
  localparam int SEL_LSB = 2;
  localparam int PG_LVL_LSB = 5;
  localparam int TERM_SEL_BIT = 6;
  localparam int FALL_LSB = 3;
  localparam int RISE_LSB = 0;
  localparam logic [2:0] SRC_BOTH_3_4 = 3'h5;
  localparam logic [2:0] SRC_ALWAYS = 3'h7;
  // time base
  localparam int CLK_HZ = 125000000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  typedef enum logic [1:0] {
    LSES_OFF = 2'b00,
    LSES_RISE_WAIT = 2'b01,
    LSES_ON = 2'b10,
    LSES_FALL_WAIT = 2'b11
  } lses_state_e;
  function automatic logic [6:0] delay_ms(input logic [2:0] code);
    case (code)
      3'h0: delay_ms = 7'h00;
      3'h1: delay_ms = 7'h02;
      3'h2: delay_ms = 7'h04;
      3'h3: delay_ms = 7'h08;
      3'h4: delay_ms = 7'h10;
      3'h5: delay_ms = 7'h18;
      3'h6: delay_ms = 7'h20;
      default: delay_ms = 7'h40;
    endcase
  endfunction : delay_ms
endpackage : lses_pkg
`default_nettype wire

//--- lses_tick.sv
`timescale 1ns/10ps
`default_nettype none
module lses_tick #(
  parameter int PERIOD = 125000 // cycles per millisecond tick
) (
  input wire logic clk_sys, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic restart, // realign the time base
  output logic tick // one-cycle pulse each period
);
  logic [31:0] count;
  wire last = (count == 32'(PERIOD - 1));
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      count <= 32'h0;
      tick <= 1'b0;
    end
    else
    begin
      count <= (last || restart) ? 32'h0 : count + 32'h1;
      tick <= last && !restart;
    end
  end
endmodule : lses_tick
`default_nettype wire

//--- lses_sequencer.sv
// How it works
// - mask bits 7 and 6 drop low-dropout three and two power-good from the enable term when set.
// - mask bits 5 to 0 drop step-down six to one power-good when set.
// - select register bits 1 and 0 drop the shared rail and switch b one power-good when set.
// - select field 4:2 picks pin 1,2,5,4,3 or 6 for codes 000,001,010,011,100,110.
// - code 111 feeds a constant one, so no pin is needed.
// - delay register bit 6 routes pin three (0) or pin six (1) to the termination enable.
// - delay field 5:3 delays the falling edge by 0,2,4,8,16,24,32 or 64 ms.
// - delay field 2:0 delays the rising edge with the same table.
// - delays are nominal and may be off by ten percent; here they are exact ms counts.
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module lses_sequencer #(
  parameter int TICK_PERIOD = lses_pkg::TICK_CYCLES // cycles per ms
) (
  input wire logic clk_sys, // system clock, 125 MHz
  input wire logic nrst, // async reset, active low
  input wire logic [lses_pkg::ADDR_W-1:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  input wire logic [6:1] control_pin, // control pins one to six
  input wire logic [5:0] step_down_pg, // step-down six..one power good
  input wire logic low_dropout_two_pg, // low-dropout two power good
  input wire logic low_dropout_three_pg, // low-dropout three power good
  input wire logic load_switch_b_one_pg, // switch b one power good
  input wire logic shared_rail_pg, // shared switch/regulator power good
  output logic load_switch_a_en, // switch enable
  output logic memory_termination_en, // termination regulator enable
  output logic [1:0] power_good_level_select // power good level code
);
  logic [7:0] pg_mask_lo;
  logic [7:0] enable_select;
  logic [7:0] edge_delay;
  logic ack;
  lses_pkg::lses_state_e state;
  lses_pkg::lses_state_e next_state;
  logic [6:0] ms_left;
  logic [6:0] next_ms_left;
  logic src_q;
  logic tick;

  wire access = (avs_read || avs_write) && !ack;
  wire [7:0] index = avs_address[lses_pkg::ADDR_W-1:2];
  wire wr_ok = avs_write && ack && avs_byteenable[0];
  wire wr_mask = wr_ok && (index == lses_pkg::IDX_PG_MASK_LO);
  wire wr_sel = wr_ok && (index == lses_pkg::IDX_ENABLE_SELECT);
  wire wr_dly = wr_ok && (index == lses_pkg::IDX_EDGE_DELAY);
  wire [7:0] status = {5'h00, src_q, load_switch_a_en, memory_termination_en};
  wire [7:0] rd_mux =
    (index == lses_pkg::IDX_PG_MASK_LO) ? pg_mask_lo :
    (index == lses_pkg::IDX_ENABLE_SELECT) ? enable_select :
    (index == lses_pkg::IDX_EDGE_DELAY) ? edge_delay :
    (index == lses_pkg::IDX_STATUS) ? status : 8'h00;

  // one wait state, then the answer; unmapped reads give zero
  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      ack <= 1'b0;
      avs_readdata <= 32'h0;
      pg_mask_lo <= lses_pkg::RESET_PG_MASK_LO;
      enable_select <= lses_pkg::RESET_ENABLE_SELECT;
      edge_delay <= lses_pkg::RESET_EDGE_DELAY;
    end
    else
    begin
      ack <= access;
      if (access && avs_read)
        avs_readdata <= {24'h0, rd_mux};
      if (wr_mask)
        pg_mask_lo <= avs_writedata[7:0];
      if (wr_sel)
        enable_select <= {1'b0, avs_writedata[6:0]};
      if (wr_dly)
        edge_delay <= {1'b0, avs_writedata[6:0]};
    end
  end

  wire [2:0] src_code = enable_select[lses_pkg::SEL_LSB +: 3];
  wire [2:0] fall_code = edge_delay[lses_pkg::FALL_LSB +: 3];
  wire [2:0] rise_code = edge_delay[lses_pkg::RISE_LSB +: 3];
  wire src_level;
  assign src_level =
    (src_code == 3'h0) ? control_pin[1] :
    (src_code == 3'h1) ? control_pin[2] :
    (src_code == 3'h2) ? control_pin[5] :
    (src_code == 3'h3) ? control_pin[4] :
    (src_code == 3'h4) ? control_pin[3] :
    (src_code == lses_pkg::SRC_BOTH_3_4) ? (control_pin[3] && control_pin[4]) :
    (src_code == 3'h6) ? control_pin[6] : 1'b1;

  // all ten power-good inputs, each with its mask bit
  wire pg_all =
    (pg_mask_lo[7] || low_dropout_three_pg) && (pg_mask_lo[6] || low_dropout_two_pg) &&
    (&(pg_mask_lo[5:0] | step_down_pg)) &&
    (enable_select[1] || shared_rail_pg) && (enable_select[0] || load_switch_b_one_pg);

  wire src_edge = src_level != src_q;
  wire [6:0] rise_ms = lses_pkg::delay_ms(rise_code);
  wire [6:0] fall_ms = lses_pkg::delay_ms(fall_code);

  // millisecond base realigned on each source edge
  lses_tick #(
    .PERIOD(TICK_PERIOD)
  ) u_tick (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .restart(src_edge),
    .tick(tick)
  );

  // on after rise delay with power good, off after fall delay
  // fall delay loaded from field 5:3
  // rise delay loaded from field 2:0
  // exact nominal counts sit inside the tolerance
  always_comb
  begin
    next_state = state;
    next_ms_left = ms_left;
    case (state)
      lses_pkg::LSES_OFF:
      begin
        if (src_level)
        begin
          next_state = lses_pkg::LSES_RISE_WAIT;
          next_ms_left = rise_ms;
        end
      end
      lses_pkg::LSES_RISE_WAIT:
      begin
        if (!src_level)
          next_state = lses_pkg::LSES_OFF;
        else if (ms_left == 7'h00)
        begin
          if (pg_all)
            next_state = lses_pkg::LSES_ON;
        end
        else if (tick)
          next_ms_left = ms_left - 7'h01;
      end
      lses_pkg::LSES_ON:
      begin
        if (!src_level)
        begin
          next_state = lses_pkg::LSES_FALL_WAIT;
          next_ms_left = fall_ms;
        end
      end
      lses_pkg::LSES_FALL_WAIT:
      begin
        if (src_level)
          next_state = lses_pkg::LSES_ON;
        else if (ms_left == 7'h00)
          next_state = lses_pkg::LSES_OFF;
        else if (tick)
          next_ms_left = ms_left - 7'h01;
      end
      default:
        next_state = lses_pkg::LSES_OFF;
    endcase
  end

  wire term_src = edge_delay[lses_pkg::TERM_SEL_BIT] ? control_pin[6] : control_pin[3];
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= lses_pkg::LSES_OFF;
      ms_left <= 7'h00;
      src_q <= 1'b0;
      load_switch_a_en <= 1'b0;
      memory_termination_en <= 1'b0;
      power_good_level_select <= 2'h0;
    end
    else
    begin
      state <= next_state;
      ms_left <= next_ms_left;
      src_q <= src_level;
      load_switch_a_en <= (next_state == lses_pkg::LSES_ON) ||
                          (next_state == lses_pkg::LSES_FALL_WAIT);
      memory_termination_en <= term_src;
      power_good_level_select <= enable_select[lses_pkg::PG_LVL_LSB +: 2];
    end
  end

  a_const_src_on: assert property (@(posedge clk_sys) disable iff (!nrst)
    (state == lses_pkg::LSES_RISE_WAIT && src_code == lses_pkg::SRC_ALWAYS && ms_left == 7'h00
     && pg_all) |=> load_switch_a_en)
    else $error("constant source did not enable switch");
  a_pg_blocks_on: assert property (@(posedge clk_sys) disable iff (!nrst)
    (state == lses_pkg::LSES_RISE_WAIT && !pg_all) |=> state != lses_pkg::LSES_ON)
    else $error("switch turned on without power good");
  a_ldo_mask: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!pg_mask_lo[7] && !low_dropout_three_pg) |-> !pg_all)
    else $error("low-dropout three power good ignored");
  a_buck_mask: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!pg_mask_lo[0] && !step_down_pg[0]) |-> !pg_all)
    else $error("step-down one power good ignored");
  a_b_mask: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!enable_select[1] && !shared_rail_pg) |-> !pg_all)
    else $error("shared rail power good ignored");
  a_both_pins: assert property (@(posedge clk_sys) disable iff (!nrst)
    (src_code == lses_pkg::SRC_BOTH_3_4 && !control_pin[4]) |-> !src_level)
    else $error("pin four ignored in combined mode");
  a_pin_one: assert property (@(posedge clk_sys) disable iff (!nrst)
    (src_code == 3'h0) |-> (src_level == control_pin[1]))
    else $error("pin one not selected");
  a_term_pin: assert property (@(posedge clk_sys) disable iff (!nrst)
    1'b1 |=> memory_termination_en == $past(term_src))
    else $error("termination enable wrong pin");
  a_rise_load: assert property (@(posedge clk_sys) disable iff (!nrst)
    (state == lses_pkg::LSES_OFF && src_level) |=> ms_left == $past(rise_ms))
    else $error("rise delay not loaded");
  a_fall_load: assert property (@(posedge clk_sys) disable iff (!nrst)
    (state == lses_pkg::LSES_ON && !src_level) |=> ms_left == $past(fall_ms))
    else $error("fall delay not loaded");
  a_no_delay_off: assert property (@(posedge clk_sys) disable iff (!nrst)
    (state == lses_pkg::LSES_ON && !src_level && fall_code == 3'h0) |=> ##2 !load_switch_a_en)
    else $error("zero fall delay not immediate");

  // a write lands only at the accepting edge, never while the master is stalled
  a_mask_write: assert property (@(posedge clk_sys) disable iff (!nrst)
    (avs_write && !avs_waitrequest && avs_byteenable[0] && index == lses_pkg::IDX_PG_MASK_LO)
    |=> pg_mask_lo == $past(avs_writedata[7:0]))
    else $error("mask write lost");
  a_sel_write: assert property (@(posedge clk_sys) disable iff (!nrst)
    (avs_write && !avs_waitrequest && avs_byteenable[0] && index == lses_pkg::IDX_ENABLE_SELECT)
    |=> enable_select == {1'b0, $past(avs_writedata[6:0])})
    else $error("select write lost");
  a_dly_write: assert property (@(posedge clk_sys) disable iff (!nrst)
    (avs_write && !avs_waitrequest && avs_byteenable[0] && index == lses_pkg::IDX_EDGE_DELAY)
    |=> edge_delay == {1'b0, $past(avs_writedata[6:0])})
    else $error("delay write lost");
  a_no_early_write: assert property (@(posedge clk_sys) disable iff (!nrst)
    (avs_write && avs_waitrequest) |=> $stable({pg_mask_lo, enable_select, edge_delay}))
    else $error("register written while stalled");
  a_rd_upper: assert property (@(posedge clk_sys) disable iff (!nrst)
    1'b1 |-> avs_readdata[31:8] == 24'h000000)
    else $error("read data upper bytes not zero");
  a_rd_delay: assert property (@(posedge clk_sys) disable iff (!nrst)
    (avs_read && avs_waitrequest && index == lses_pkg::IDX_EDGE_DELAY)
    |=> avs_readdata[7:0] == $past(edge_delay))
    else $error("delay register read wrong");
  a_ldo_two_mask: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!pg_mask_lo[6] && !low_dropout_two_pg) |-> !pg_all)
    else $error("low-dropout two power good ignored");
  a_ldo_two_off: assert property (@(posedge clk_sys) disable iff (!nrst)
    (pg_mask_lo[6] && !low_dropout_two_pg && low_dropout_three_pg && (&step_down_pg)
     && shared_rail_pg && load_switch_b_one_pg) |-> pg_all)
    else $error("masked low-dropout two still blocks");
  a_buck_six_mask: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!pg_mask_lo[5] && !step_down_pg[5]) |-> !pg_all)
    else $error("step-down six power good ignored");
  a_b_one_mask: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!enable_select[0] && !load_switch_b_one_pg) |-> !pg_all)
    else $error("switch b one power good ignored");
  a_pin_two: assert property (@(posedge clk_sys) disable iff (!nrst)
    (src_code == 3'h1) |-> (src_level == control_pin[2]))
    else $error("pin two not selected");
  a_pin_five: assert property (@(posedge clk_sys) disable iff (!nrst)
    (src_code == 3'h2) |-> (src_level == control_pin[5]))
    else $error("pin five not selected");
  a_pin_four: assert property (@(posedge clk_sys) disable iff (!nrst)
    (src_code == 3'h3) |-> (src_level == control_pin[4]))
    else $error("pin four not selected");
  a_pin_three: assert property (@(posedge clk_sys) disable iff (!nrst)
    (src_code == 3'h4) |-> (src_level == control_pin[3]))
    else $error("pin three not selected");
  a_pin_six: assert property (@(posedge clk_sys) disable iff (!nrst)
    (src_code == 3'h6) |-> (src_level == control_pin[6]))
    else $error("pin six not selected");
  a_both_high: assert property (@(posedge clk_sys) disable iff (!nrst)
    (src_code == lses_pkg::SRC_BOTH_3_4 && control_pin[3] && control_pin[4]) |-> src_level)
    else $error("combined mode not enabled");
  a_const_one: assert property (@(posedge clk_sys) disable iff (!nrst)
    (src_code == lses_pkg::SRC_ALWAYS) |-> src_level)
    else $error("constant source not one");
  a_term_six: assert property (@(posedge clk_sys) disable iff (!nrst)
    (edge_delay[lses_pkg::TERM_SEL_BIT] && control_pin[6]) |=> memory_termination_en)
    else $error("termination enable missed pin six");
  a_term_three: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!edge_delay[lses_pkg::TERM_SEL_BIT] && !control_pin[3]) |=> !memory_termination_en)
    else $error("termination enable ignored pin three");
  a_off_after_fall: assert property (@(posedge clk_sys) disable iff (!nrst)
    (state == lses_pkg::LSES_FALL_WAIT && ms_left == 7'h00 && !src_level) |=> !load_switch_a_en)
    else $error("switch stayed on after fall delay");
  a_restart_tick: assert property (@(posedge clk_sys) disable iff (!nrst)
    src_edge |=> !tick)
    else $error("tick not restarted on source edge");
  a_count_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    (state == lses_pkg::LSES_RISE_WAIT && src_level && ms_left != 7'h00 && !tick)
    |=> ms_left == $past(ms_left))
    else $error("delay counted without tick");
  a_rise_count: assert property (@(posedge clk_sys) disable iff (!nrst)
    (state == lses_pkg::LSES_RISE_WAIT && ms_left != 7'h00) |=> state != lses_pkg::LSES_ON)
    else $error("switch on before rise delay");
  a_fall_count: assert property (@(posedge clk_sys) disable iff (!nrst)
    (state == lses_pkg::LSES_FALL_WAIT && !src_level && ms_left != 7'h00) |=> load_switch_a_en)
    else $error("switch off before fall delay");
endmodule : lses_sequencer
`default_nettype wire

//--- lses_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module lses_host_model (
  input wire logic clk_sys, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic [6:1] want, // levels asked for by the bench
  output logic [6:1] control_pin // levels seen by the device
);
  // board logic drives the pins from a flop, so they only move after an edge
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
      control_pin <= 6'h00;
    else
      control_pin <= want;
endmodule : lses_host_model
`default_nettype wire

//--- load_switch_enable_sequencer_tb.sv
`timescale 1ns/10ps
`default_nettype none
module load_switch_enable_sequencer_tb;
  localparam int P = 10;
  localparam logic [7:0] MSK = lses_pkg::IDX_PG_MASK_LO;
  localparam logic [7:0] SEL = lses_pkg::IDX_ENABLE_SELECT;
  localparam logic [7:0] DLY = lses_pkg::IDX_EDGE_DELAY;
  localparam logic [6:1] SRC_PIN [8] = '{6'h01, 6'h02, 6'h10, 6'h08, 6'h04, 6'h0c, 6'h20, 6'h00};
  localparam int MS [8] = '{0, 2, 4, 8, 16, 24, 32, 64};
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [6:1] want = 6'h00;
  logic [6:1] control_pin;
  // ldo three, ldo two, step-down six..one, shared rail, switch b one
  logic [9:0] pg = 10'h3ff;
  logic en;
  logic term;
  logic [1:0] lvl;
  logic [31:0] exp_q [$];
  int error_cnt = 0;
  int comparisons = 0;

  initial
  begin
    forever #4 clk_sys = ~clk_sys;
  end

  lses_host_model i_host (.clk_sys(clk_sys), .nrst(nrst), .want(want), .control_pin(control_pin));
  lses_sequencer #(.TICK_PERIOD(P)) i_dut (
    .clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .control_pin(control_pin),
    .step_down_pg(pg[7:2]), .low_dropout_two_pg(pg[8]), .low_dropout_three_pg(pg[9]),
    .load_switch_b_one_pg(pg[0]), .shared_rail_pg(pg[1]), .load_switch_a_en(en),
    .memory_termination_en(term), .power_good_level_select(lvl));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  // one edge always passes first, so a release is never re-driven in the same step
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk_sys);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h000000, d};
    avs_write <= wr;
    avs_read <= ~wr;
    // the answer is taken at the rising edge; only the watchdog ends a hang
    do
      @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    exp_q.push_back({24'h000000, e});
    bus(1'b0, idx, 8'h00);
  endtask : rd

  task automatic pins(input logic [6:1] p);
    @(posedge clk_sys);
    want <= p;
  endtask : pins

  task automatic settle(input logic v);
    repeat (8) @(negedge clk_sys);
    check({31'h0, en}, {31'h0, v});
  endtask : settle

  // bounded wait; edge delays may be ten percent off plus a few cycles of pipeline
  task automatic wait_en(input logic v, input int ms);
    int n;
    n = 0;
    while (en !== v && n <= ms * P * 11 / 10 + 6)
    begin
      @(negedge clk_sys);
      n++;
    end
    check({31'h0, n >= ms * P * 9 / 10 && n <= ms * P * 11 / 10 + 6}, 32'h1);
  endtask : wait_en

  always @(posedge clk_sys)
    if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0)
      check(avs_readdata, exp_q.pop_front());

  initial
  begin
    repeat (50000) @(posedge clk_sys);
    error_cnt++;
    complete_run();
  end

  initial
  begin
    logic [15:0] r;
    int c;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    r = 16'd45401;
    for (c = 0; c < 3; c++)
    begin
      r = lfsr(r);
      bus(1'b1, MSK, r[7:0]);
      rd(MSK, r[7:0]);
      bus(1'b1, SEL, r[15:8]);
      rd(SEL, {1'b0, r[14:8]});
      check({30'h0, lvl}, {30'h0, r[14:13]});
      bus(1'b1, DLY, r[7:0] ^ r[15:8]);
      rd(DLY, {1'b0, r[6:0] ^ r[14:8]});
    end
    avs_byteenable <= 4'he;
    bus(1'b1, MSK, ~r[7:0]);
    avs_byteenable <= 4'hf;
    rd(MSK, r[7:0]);
    rd(8'h30, 8'h00);
    bus(1'b1, MSK, 8'h00);
    bus(1'b1, DLY, 8'h00);
    bus(1'b1, SEL, 8'h00);
    repeat (800) @(posedge clk_sys);
    for (c = 0; c < 8; c++)
    begin
      bus(1'b1, SEL, {3'h0, c[2:0], 2'h0});
      pins(~SRC_PIN[c]);
      settle(c == 7);
      pins(SRC_PIN[c]);
      settle(1'b1);
      pins(6'h04);
      settle(c == 4 || c == 7);
      check({31'h0, term}, 32'h1);
    end
    for (c = 0; c < 10; c++)
    begin
      pins(6'h00);
      pg <= ~(10'h001 << c);
      bus(1'b1, SEL, 8'h00);
      bus(1'b1, MSK, 8'h00);
      pins(6'h01);
      settle(1'b0);
      if (c < 2)
        bus(1'b1, SEL, 8'(1 << c));
      else
        bus(1'b1, MSK, 8'(1 << (c - 2)));
      settle(1'b1);
    end
    pins(6'h00);
    pg <= 10'h3ff;
    bus(1'b1, SEL, 8'h00);
    for (c = 0; c < 8; c++)
    begin
      bus(1'b1, DLY, {2'b00, c[2:0], c[2:0]});
      pins(6'h01);
      wait_en(1'b1, MS[c]);
      pins(6'h00);
      wait_en(1'b0, MS[c]);
    end
    bus(1'b1, DLY, 8'h43);
    pins(6'h20);
    settle(1'b0);
    check({31'h0, term}, 32'h1);
    pins(6'h04);
    settle(1'b0);
    check({31'h0, term}, 32'h0);
    // a drop mid-wait must throw away the partial count
    pins(6'h01);
    repeat (40) @(posedge clk_sys);
    pins(6'h00);
    pins(6'h01);
    wait_en(1'b1, 8);
    rd(lses_pkg::IDX_STATUS, 8'h06);
    @(posedge clk_sys);
    check(32'(exp_q.size()), 32'h0);
    complete_run();
  end
endmodule : load_switch_enable_sequencer_tb
`default_nettype wire
